// >>> src/bcls_sequencer.sv
// Courtesy light sequencer with APB register access.
// Barrier state inputs come from logic on i_clock.
//
// The APB register port and the address map were chosen for this implementation.
`timescale 1ns/100ps
`include "bcls_params.svh"
module bcls_sequencer #(
  parameter int TICK_CYC  = `BCLS_TICK_CYC,
  parameter int FLASH_CYC = `BCLS_FLASH_CYC
) (
  input  wire logic        i_clock,
  input  wire logic        i_reset_n,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_moving,
  input  wire logic        i_pre_open,
  input  wire logic        i_pre_close,
  input  wire logic        i_manual,
  input  wire logic        i_spare_bidir_in,
  output logic             o_spare_bidir_out,
  output logic             o_spare_bidir_oe_n,
  output logic             o_contact_output,
  output logic             o_aux_drain_oe_n,
  output logic             o_status_lamp
);

  localparam int TW = $clog2(TICK_CYC + 1);
  localparam int FW = $clog2(FLASH_CYC + 1);

  // Register state
  logic                      en_r, en_nxt;
  bcls_pkg::bcls_route_type   route_r, route_nxt;
  bcls_pkg::bcls_profile_type prof_r, prof_nxt;
  logic [15:0]               time_r, time_nxt;
  logic [31:0]               rdata_r, rdata_nxt;
  logic                      ready_r, ready_nxt;
  logic                      err_r, err_nxt;

  // Sequencer state
  bcls_pkg::bcls_state_type   state_r, state_nxt;
  logic [15:0]               sec_r, sec_nxt;
  logic [TW-1:0]             tcnt_r, tcnt_nxt;
  logic                      tick;
  logic [FW-1:0]             fcnt_r, fcnt_nxt;
  logic                      fon_r, fon_nxt;
  logic                      powered_r, powered_nxt;
  logic                      light_r, light_nxt;
  logic [3:0]                outs_r, outs_nxt;
  logic [1:0]                pin_sync_r;

  logic act, flashing, wr, mapped;
  logic [15:0] wtime;

  assign act = i_moving | i_pre_open | i_pre_close;
  assign flashing = (prof_r ==
    bcls_pkg::BCLS_FLASHING_PRESTART_PROFILE) && act;
  assign mapped = (i_paddr == `BCLS_OFS_CTRL) ||
                  (i_paddr == `BCLS_OFS_TIME) ||
                  (i_paddr == `BCLS_OFS_STAT);
  assign wr = i_psel & i_penable & i_pwrite & ready_r & ~err_r;
  assign tick = (tcnt_r == TW'(TICK_CYC - 1));

  always_comb begin
    wtime = i_pwdata[15:0];
    if (wtime < `BCLS_TIME_MIN) begin
      wtime = `BCLS_TIME_MIN;
    end else if (wtime > `BCLS_TIME_MAX) begin
      wtime = `BCLS_TIME_MAX;
    end
  end

  // APB slave: one setup cycle, one access cycle
  always_comb begin
    en_nxt    = en_r;
    route_nxt = route_r;
    prof_nxt  = prof_r;
    time_nxt  = time_r;
    ready_nxt = i_psel & ~i_penable;
    err_nxt   = i_psel & ~i_penable & ~mapped;
    rdata_nxt = 32'h0;
    if (i_psel && !i_penable && !i_pwrite) begin
      case (i_paddr)
        `BCLS_OFS_CTRL: begin
          rdata_nxt[`BCLS_CTRL_EN] = en_r;
          rdata_nxt[`BCLS_CTRL_RT_HI:`BCLS_CTRL_RT_LO] = route_r;
          rdata_nxt[`BCLS_CTRL_PR_HI:`BCLS_CTRL_PR_LO] = prof_r;
        end
        `BCLS_OFS_TIME: rdata_nxt[15:0] = time_r;
        `BCLS_OFS_STAT: begin
          rdata_nxt[0] = light_r;
          rdata_nxt[1] = (state_r == bcls_pkg::BCLS_PHASE);
          rdata_nxt[3:2] = state_r;
          rdata_nxt[4] = pin_sync_r[1];
          rdata_nxt[31:16] = sec_r;
        end
        default: rdata_nxt = 32'h0;
      endcase
    end
    if (wr) begin
      case (i_paddr)
        `BCLS_OFS_CTRL: begin
          en_nxt = i_pwdata[`BCLS_CTRL_EN];
          route_nxt = bcls_pkg::bcls_route_type'(
            i_pwdata[`BCLS_CTRL_RT_HI:`BCLS_CTRL_RT_LO]);
          prof_nxt = bcls_pkg::bcls_profile_type'(
            i_pwdata[`BCLS_CTRL_PR_HI:`BCLS_CTRL_PR_LO]);
        end
        `BCLS_OFS_TIME: time_nxt = wtime;
        default: time_nxt = time_r;
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      en_r    <= 1'b0;
      route_r <= bcls_pkg::BCLS_CONTACT_OUTPUT;
      prof_r  <= bcls_pkg::BCLS_COURTESY_PROFILE;
      time_r  <= `BCLS_TIME_RST;
      rdata_r <= 32'h0;
      ready_r <= 1'b0;
      err_r   <= 1'b0;
    end else begin
      en_r    <= en_nxt;
      route_r <= route_nxt;
      prof_r  <= prof_nxt;
      time_r  <= time_nxt;
      rdata_r <= rdata_nxt;
      ready_r <= ready_nxt;
      err_r   <= err_nxt;
    end
  end

  // Pin read-back synchroniser
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      pin_sync_r <= 2'h0;
    end else begin
      pin_sync_r <= {pin_sync_r[0], i_spare_bidir_in};
    end
  end

  // Motion phase machine and second counter
  always_comb begin
    state_nxt   = state_r;
    sec_nxt     = sec_r;
    powered_nxt = powered_r;
    tcnt_nxt    = tick ? TW'(0) : tcnt_r + TW'(1);
    case (state_r)
      bcls_pkg::BCLS_IDLE: begin
        if (act) begin
          state_nxt = bcls_pkg::BCLS_ACTIVE;
          powered_nxt = i_moving & ~i_manual;
        end
      end
      bcls_pkg::BCLS_ACTIVE: begin
        if (i_moving && !i_manual) begin
          powered_nxt = 1'b1;
        end
        if (!act) begin
          if (powered_r) begin
            state_nxt = bcls_pkg::BCLS_PHASE;
            sec_nxt = time_r;
            tcnt_nxt = TW'(0);
          end else begin
            state_nxt = bcls_pkg::BCLS_IDLE;
          end
        end
      end
      bcls_pkg::BCLS_PHASE: begin
        if (act) begin
          state_nxt = bcls_pkg::BCLS_ACTIVE;
          powered_nxt = i_moving & ~i_manual;
          sec_nxt = time_r;
        end else if (tick) begin
          if (sec_r <= 16'h0001) begin
            state_nxt = bcls_pkg::BCLS_IDLE;
            sec_nxt = 16'h0;
          end else begin
            sec_nxt = sec_r - 16'h0001;
          end
        end
      end
      default: state_nxt = bcls_pkg::BCLS_IDLE;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      state_r   <= bcls_pkg::BCLS_IDLE;
      sec_r     <= 16'h0;
      tcnt_r    <= '0;
      powered_r <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      sec_r     <= sec_nxt;
      tcnt_r    <= tcnt_nxt;
      powered_r <= powered_nxt;
    end
  end

  always_comb begin
    fcnt_nxt = '0;
    fon_nxt  = 1'b1;
    if (flashing) begin
      if (fcnt_r == FW'(FLASH_CYC - 1)) begin
        fon_nxt = ~fon_r;
      end else begin
        fcnt_nxt = fcnt_r + FW'(1);
        fon_nxt = fon_r;
      end
    end
  end

  // Profile decode and output routing
  always_comb begin
    case (prof_r)
      bcls_pkg::BCLS_COURTESY_PROFILE:
        light_nxt = act | (state_r == bcls_pkg::BCLS_PHASE);
      bcls_pkg::BCLS_MOVING_ONLY_PROFILE:
        light_nxt = i_moving;
      // flash in motion
      // Light follows the flasher phase, so each half lasts FLASH_CYC
      bcls_pkg::BCLS_FLASHING_PRESTART_PROFILE:
        light_nxt = act & fon_r;
      default: light_nxt = act;
    endcase
    outs_nxt = 4'h0;
    if (en_r) begin
      outs_nxt[route_r] = light_nxt;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      fcnt_r  <= '0;
      fon_r   <= 1'b1;
      light_r <= 1'b0;
      outs_r  <= 4'h0;
    end else begin
      fcnt_r  <= fcnt_nxt;
      fon_r   <= fon_nxt;
      light_r <= light_nxt;
      outs_r  <= outs_nxt;
    end
  end

  // Port drive, open-drain pins pull low when lit
  assign o_prdata = rdata_r;
  assign o_pready = ready_r;
  assign o_pslverr = err_r;
  assign o_contact_output = outs_r[0];
  assign o_spare_bidir_out = 1'b0;
  assign o_spare_bidir_oe_n = ~outs_r[1];
  assign o_aux_drain_oe_n = ~outs_r[2];
  assign o_status_lamp = outs_r[3];

  // Checks
  a_reset_disable: assert property (@(posedge i_clock)
    !i_reset_n |=> !en_r) else $error("enable not cleared");
  a_disabled_dark: assert property (@(posedge i_clock)
    disable iff (!i_reset_n) !en_r |=> outs_r == 4'h0)
    else $error("output active while disabled");
  a_route_single: assert property (@(posedge i_clock)
    disable iff (!i_reset_n) $onehot0(outs_r))
    else $error("more than one output active");
  a_route_follow: assert property (@(posedge i_clock)
    disable iff (!i_reset_n) en_r && light_nxt |=> outs_r[$past(route_r)])
    else $error("enabled light not routed");
  a_courtesy_motion: assert property (@(posedge i_clock)
    disable iff (!i_reset_n)
    prof_r == bcls_pkg::BCLS_COURTESY_PROFILE && act |=> light_r)
    else $error("courtesy light off in motion");
  a_moving_only: assert property (@(posedge i_clock)
    disable iff (!i_reset_n)
    prof_r == bcls_pkg::BCLS_MOVING_ONLY_PROFILE |=> light_r == $past(i_moving))
    else $error("moving-only light wrong");
  a_flash_start: assert property (@(posedge i_clock)
    disable iff (!i_reset_n) $rose(flashing) |=> light_r)
    else $error("flash did not start on");
  a_steady_on: assert property (@(posedge i_clock)
    disable iff (!i_reset_n)
    prof_r == bcls_pkg::BCLS_STEADY_PRESTART_PROFILE |=> light_r == $past(act))
    else $error("steady light wrong");
  a_phase_entry: assert property (@(posedge i_clock)
    disable iff (!i_reset_n)
    state_r == bcls_pkg::BCLS_ACTIVE && !act && powered_r
    |=> state_r == bcls_pkg::BCLS_PHASE && sec_r == $past(time_r))
    else $error("phase not entered");
  a_manual_rest: assert property (@(posedge i_clock)
    disable iff (!i_reset_n)
    state_r == bcls_pkg::BCLS_ACTIVE && !act && !powered_r
    |=> state_r == bcls_pkg::BCLS_IDLE) else $error("manual rest lit");
  a_phase_expiry: assert property (@(posedge i_clock)
    disable iff (!i_reset_n)
    state_r == bcls_pkg::BCLS_PHASE && !act && tick && sec_r == 16'h0001
    |=> state_r == bcls_pkg::BCLS_IDLE) else $error("phase did not end");
  a_time_range: assert property (@(posedge i_clock)
    disable iff (!i_reset_n)
    time_r >= `BCLS_TIME_MIN && time_r <= `BCLS_TIME_MAX)
    else $error("time out of range");
  a_tick_step: assert property (@(posedge i_clock)
    disable iff (!i_reset_n)
    state_r == bcls_pkg::BCLS_PHASE && !act && tick && sec_r > 16'h0001
    |=> sec_r == $past(sec_r) - 16'h0001) else $error("bad decrement");
  // Flash, rest and phase checks
  a_flash_toggle: assert property (@(posedge i_clock)
    disable iff (!i_reset_n) flashing && fcnt_r == FW'(FLASH_CYC - 1)
    |=> fon_r != $past(fon_r)) else $error("flasher did not toggle");
  a_idle_dark: assert property (@(posedge i_clock)
    disable iff (!i_reset_n) prof_r == bcls_pkg::BCLS_COURTESY_PROFILE
    && state_r == bcls_pkg::BCLS_IDLE && !act |=> !light_r)
    else $error("courtesy light on at idle");
  a_phase_lit: assert property (@(posedge i_clock)
    disable iff (!i_reset_n) prof_r == bcls_pkg::BCLS_COURTESY_PROFILE
    && state_r == bcls_pkg::BCLS_PHASE |=> light_r)
    else $error("courtesy light off in phase");
  c_phase_end: cover property (@(posedge i_clock)
    state_r == bcls_pkg::BCLS_PHASE ##1 state_r == bcls_pkg::BCLS_IDLE);
  c_flash_off: cover property (@(posedge i_clock) flashing && !light_r);
  c_manual_rest: cover property (@(posedge i_clock)
    state_r == bcls_pkg::BCLS_ACTIVE && !act && !powered_r);
  c_ctrl_write: cover property (@(posedge i_clock)
    wr && i_paddr == `BCLS_OFS_CTRL && i_pwdata[0]);

endmodule : bcls_sequencer

// >>> src/bcls_params.svh
// Constants for the courtesy light sequencer.
// Assumes a 40 MHz system clock and APB access.
// Behaviour
// - Feature enable switchable on its own
// - Enable cleared by reset
// - Disabled forces selected output inactive
// - Light routed to exactly one output
// - Profile selects one of four behaviours
// - Courtesy profile lit during motion, pre-delays
// - Courtesy profile lit for time at rest
// - Moving-only profile lit only while moving
// - Flashing profile toggles in motion, pre-delays
// - Steady profile lit where flashing would flash
// - Phase starts after powered, not manual, movement
// - Phase lights courtesy profile, ends on expiry
// - Phase time 4 s to 35999 s
`ifndef BCLS_PARAMS_SVH
`define BCLS_PARAMS_SVH
`define BCLS_CLK_HZ      40000000
`define BCLS_TICK_S      1
`define BCLS_TICK_CYC    (`BCLS_CLK_HZ * `BCLS_TICK_S)
`define BCLS_FLASH_MS    500
`define BCLS_FLASH_CYC   ((`BCLS_CLK_HZ / 1000) * `BCLS_FLASH_MS)
`define BCLS_OFS_CTRL    8'h00
`define BCLS_OFS_TIME    8'h04
`define BCLS_OFS_STAT    8'h08
`define BCLS_CTRL_EN     0
`define BCLS_CTRL_RT_LO  1
`define BCLS_CTRL_RT_HI  2
`define BCLS_CTRL_PR_LO  4
`define BCLS_CTRL_PR_HI  5
`define BCLS_TIME_MIN    16'h0004
`define BCLS_TIME_MAX    16'h8c9f
`define BCLS_TIME_RST    16'h001e
`endif

// >>> src/bcls_pkg.sv
// Types for the courtesy light sequencer.
// Used with package-qualified names only.
package bcls_pkg;
  typedef enum logic [1:0] {
    BCLS_IDLE   = 2'h0,
    BCLS_ACTIVE = 2'h1,
    BCLS_PHASE  = 2'h3
  } bcls_state_type;
  typedef enum logic [1:0] {
    BCLS_COURTESY_PROFILE = 2'h0,
    BCLS_MOVING_ONLY_PROFILE = 2'h1,
    BCLS_FLASHING_PRESTART_PROFILE = 2'h2,
    BCLS_STEADY_PRESTART_PROFILE = 2'h3
  } bcls_profile_type;
  typedef enum logic [1:0] {
    BCLS_CONTACT_OUTPUT = 2'h0,
    BCLS_SPARE_BIDIR_OUTPUT = 2'h1,
    BCLS_AUX_DRAIN = 2'h2,
    BCLS_STATUS_LAMP = 2'h3
  } bcls_route_type;
endpackage : bcls_pkg

// >>> verif/bcls_light_model.sv
// Model of the external light hardware on the four light outputs.
// Assumes the sequencer's pin levels; the spare pin has a pull-up.
`timescale 1ns/100ps
module bcls_light_model (
  input  wire logic       i_contact,
  input  wire logic       i_spare_oe_n,
  input  wire logic       i_aux_oe_n,
  input  wire logic       i_lamp,
  output logic            o_spare_pin,
  output logic      [3:0] o_lit
);
  // Released spare pin floats up to the pull-up level
  assign o_spare_pin = i_spare_oe_n ? 1'b1 : 1'b0;
  // One bit per output: contact, spare, aux, lamp
  assign o_lit = {i_lamp, ~i_aux_oe_n, ~i_spare_oe_n, i_contact};
endmodule : bcls_light_model

// >>> verif/tb_top.sv
// Self-checking bench for the courtesy light sequencer.
// Assumes short tick (20) and flash (4) counts set here.
`timescale 1ns/100ps
`include "bcls_params.svh"
module tb_top;
  logic        i_clock, i_reset_n, psel, penable, pwrite, pready, pslverr, err;
  logic        moving, pre_open, pre_close, manual, spare_out, spare_oe_n, contact, aux_oe_n, lamp, pin;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  lit;
  int          n_errors, n_tests, n_on, r;

  bcls_sequencer #(.TICK_CYC(20), .FLASH_CYC(4)) bcls_sequencer_inst (
    .i_clock(i_clock), .i_reset_n(i_reset_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_moving(moving), .i_pre_open(pre_open),
    .i_pre_close(pre_close), .i_manual(manual), .i_spare_bidir_in(pin),
    .o_spare_bidir_out(spare_out), .o_spare_bidir_oe_n(spare_oe_n),
    .o_contact_output(contact), .o_aux_drain_oe_n(aux_oe_n), .o_status_lamp(lamp));
  bcls_light_model bcls_light_model_inst (
    .i_contact(contact), .i_spare_oe_n(spare_oe_n), .i_aux_oe_n(aux_oe_n),
    .i_lamp(lamp), .o_spare_pin(pin), .o_lit(lit));

  // Clock, 25 ns period
  initial begin
    i_clock = 1'b0;
    forever #12.5 i_clock = ~i_clock;
  end

  task automatic final_report;
    $display("errors %0d comparisons %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge i_clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge i_clock);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge i_clock);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (pready !== 1'b1) begin
      n_errors++;
      final_report();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic setc(input int en, input int rt, input bcls_pkg::bcls_profile_type pf);
    apb(1'b1, `BCLS_OFS_CTRL, 32'((int'(pf) << 4) | (rt << 1) | en));
  endtask : setc

  task automatic bar(input logic mv, input logic po, input logic pc, input logic mn, input int n);
    @(posedge i_clock);
    moving    <= mv;
    pre_open  <= po;
    pre_close <= pc;
    manual    <= mn;
    repeat (n) @(posedge i_clock);
  endtask : bar

  // Lit vector must show only the routed output
  task automatic lchk(input logic on, input int rt);
    chk({28'h0, lit}, on ? (32'h1 << rt) : 32'h0);
  endtask : lchk

  // Hang guard
  initial begin
    repeat (20000) @(posedge i_clock);
    n_errors++;
    final_report();
  end

  // Main sequence
  initial begin
    {psel, penable, pwrite, moving, pre_open, pre_close, manual} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    i_reset_n = 1'b0;
    void'($urandom(90));
    repeat (3) @(posedge i_clock);
    i_reset_n <= 1'b1;
    apb(1'b0, `BCLS_OFS_CTRL, 32'h0); chk(rd, 32'h0);
    apb(1'b0, `BCLS_OFS_TIME, 32'h0); chk(rd, 32'(`BCLS_TIME_RST));
    lchk(1'b0, 0);
    apb(1'b0, 8'h0c, 32'h0); chk({31'h0, err}, 32'h1);
    apb(1'b1, `BCLS_OFS_TIME, 32'h1);
    apb(1'b0, `BCLS_OFS_TIME, 32'h0); chk(rd, 32'(`BCLS_TIME_MIN));
    apb(1'b1, `BCLS_OFS_TIME, 32'hffff);
    apb(1'b0, `BCLS_OFS_TIME, 32'h0); chk(rd, 32'(`BCLS_TIME_MAX));
    r = 4 + ($urandom % 35996);
    apb(1'b1, `BCLS_OFS_TIME, 32'(r));
    apb(1'b0, `BCLS_OFS_TIME, 32'h0); chk(rd, 32'(r));
    apb(1'b1, `BCLS_OFS_TIME, 32'h4);
    // Disabled feature keeps every output dark
    setc(0, 1, bcls_pkg::BCLS_COURTESY_PROFILE);
    bar(1'b1, 1'b0, 1'b0, 1'b0, 3); lchk(1'b0, 1);
    bar(1'b0, 1'b0, 1'b0, 1'b0, 100); lchk(1'b0, 1);
    // Courtesy profile on every route, phase of 80 cycles
    for (int rt = 0; rt < 4; rt++) begin
      setc(1, rt, bcls_pkg::BCLS_COURTESY_PROFILE);
      bar(1'b0, 1'b1, 1'b0, 1'b0, 3); lchk(1'b1, rt);
      bar(1'b1, 1'b0, 1'b0, 1'b0, 3); lchk(1'b1, rt);
      bar(1'b0, 1'b0, 1'b0, 1'b0, 40); lchk(1'b1, rt);
      repeat (60) @(posedge i_clock); lchk(1'b0, rt);
    end
    // Rest after manual movement starts no phase
    bar(1'b1, 1'b0, 1'b0, 1'b1, 4);
    bar(1'b0, 1'b0, 1'b0, 1'b0, 4); lchk(1'b0, 3);
    // New movement reloads the phase time
    bar(1'b1, 1'b0, 1'b0, 1'b0, 3);
    bar(1'b0, 1'b0, 1'b0, 1'b0, 60);
    bar(1'b1, 1'b0, 1'b0, 1'b0, 1);
    bar(1'b0, 1'b0, 1'b0, 1'b0, 60); lchk(1'b1, 3);
    repeat (40) @(posedge i_clock); lchk(1'b0, 3);
    // Disable in mid-phase
    bar(1'b1, 1'b0, 1'b0, 1'b0, 3);
    bar(1'b0, 1'b0, 1'b0, 1'b0, 10);
    setc(0, 3, bcls_pkg::BCLS_COURTESY_PROFILE);
    repeat (3) @(posedge i_clock); lchk(1'b0, 3);
    // Moving-only profile
    setc(1, 2, bcls_pkg::BCLS_MOVING_ONLY_PROFILE);
    bar(1'b0, 1'b1, 1'b0, 1'b0, 3); lchk(1'b0, 2);
    bar(1'b1, 1'b0, 1'b0, 1'b0, 3); lchk(1'b1, 2);
    bar(1'b0, 1'b0, 1'b1, 1'b0, 3); lchk(1'b0, 2);
    // Steady profile
    setc(1, 2, bcls_pkg::BCLS_STEADY_PRESTART_PROFILE);
    repeat (3) @(posedge i_clock); lchk(1'b1, 2);
    bar(1'b1, 1'b0, 1'b0, 1'b0, 3); lchk(1'b1, 2);
    bar(1'b0, 1'b0, 1'b0, 1'b0, 3); lchk(1'b0, 2);
    // Flashing profile: starts lit, half on over whole periods
    setc(1, 0, bcls_pkg::BCLS_FLASHING_PRESTART_PROFILE);
    bar(1'b0, 1'b1, 1'b0, 1'b0, 2); lchk(1'b1, 0);
    n_on = 0;
    repeat (32) begin
      @(posedge i_clock);
      n_on += (lit === 4'h1) ? 1 : 0;
    end
    chk(32'(n_on), 32'd16);
    bar(1'b0, 1'b0, 1'b0, 1'b0, 3);
    // Status: dark, idle, released spare pin reads high
    apb(1'b0, `BCLS_OFS_STAT, 32'h0); chk(rd & 32'h1f, 32'h10);
    chk({31'h0, spare_out}, 32'h0);
    final_report();
  end
endmodule : tb_top
